// ==== fpio_defines.svh ====
`ifndef FPIO_DEFINES_SVH
`define FPIO_DEFINES_SVH

// Register indices, byte address is four times the index
`define FPIO_IDX_A_DATA   4'h0
`define FPIO_IDX_B_DATA   4'h1
`define FPIO_IDX_C_DATA   4'h2
`define FPIO_IDX_D_DATA   4'h3
`define FPIO_IDX_A_DIR    4'h4
`define FPIO_IDX_B_DIR    4'h5
`define FPIO_IDX_C_DIR    4'h6
`define FPIO_IDX_D_DIR    4'h7
`define FPIO_IDX_STATUS   4'h8
`define FPIO_IDX_CLEAR    4'h9
`define FPIO_IDX_ENABLE   4'hA
`define FPIO_IDX_CONFIG   4'hB
`define FPIO_IDX_LAST     4'hB
`define FPIO_WORD_LSB     2
`define FPIO_IDX_W        4

// Field positions
`define FPIO_B_LSB        5
`define FPIO_B_MSB        7
`define FPIO_D_BIDIR_BIT  5
`define FPIO_D_INPUT_BIT  7
`define FPIO_C_SHARED     8'hF8
`define FPIO_CFG_SPE_BIT  0
`define FPIO_CFG_ADC_BIT  1
`define FPIO_CFG_PULL_BIT 2
`define FPIO_CFG_KEY_BIT  3
`define FPIO_CFG_MSB      3

// Reset values
`define FPIO_DIR_RESET    8'h00
`define FPIO_DIRB_RESET   3'h0
`define FPIO_STAT_RESET   8'h00
`define FPIO_EN_RESET     8'h00
`define FPIO_CFG_RESET    4'h0

// Bus answers
`define FPIO_RESP_OKAY    2'h0
`define FPIO_RESP_SLVERR  2'h2

`endif

// ==== fpio_pkg.sv ====
package fpio_pkg;

  typedef struct packed {
    logic [7:0] dat_a;
    logic [2:0] dat_b;
    logic [7:0] dat_c;
    logic       dat_d;
    logic [7:0] dir_a;
    logic [2:0] dir_b;
    logic [7:0] dir_c;
    logic       dir_d;
    logic [7:0] oe_a;
    logic [2:0] oe_b;
    logic [7:0] oe_c;
    logic       oe_d;
    logic [7:0] stat;
    logic [7:0] en;
    logic [3:0] cfg;
    logic [7:0] prev_a;
    logic       irq;
    logic       pull;
    logic       aw_got;
    logic [4:0] aw_sel;
    logic       w_got;
    logic [7:0] w_data;
    logic       w_strb;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } fpio_state_type;

endpackage : fpio_pkg

// ==== fpio_top.sv ====
// Functional notes
// - Direction one drives pin, zero floats it
// - Reset clears every direction register
// - Data latches survive reset, undefined at power-up
// - Read returns latch for outputs, pin otherwise
// - Writes to input pins only update latch
// - First port eight bits, data 0, direction 4
// - Second port bits 5-7, data 1, direction 5
// - Third port eight bits, data 2, direction 6
// - Fourth port bidir bit 5, input bit 7
// - Fourth direction only bit 5 implemented
// - Fourth input line always readable
// - Fourth port general I/O regardless of timer
// - Serial enable takes second port pins
// - Converter enable takes third port bits 3-7
// - First port pull-up and interrupt by option
// - Direction registers readable and writable
// - First port lines raise external interrupt events
//
// Added by the designer: register access over AXI4-Lite.
`include "fpio_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module fpio_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        port_a_in,
  output var  logic [7:0]        port_a_out,
  output var  logic [7:0]        port_a_oe,
  output var  logic              port_a_pullup,
  input  wire logic [2:0]        second_port_lines_in,
  output var  logic [2:0]        second_port_lines_out,
  output var  logic [2:0]        second_port_lines_oe,
  input  wire logic [7:0]        port_c_in,
  output var  logic [7:0]        port_c_out,
  output var  logic [7:0]        port_c_oe,
  input  wire logic              fourth_port_bidir_line_in,
  output var  logic              fourth_port_bidir_line_out,
  output var  logic              fourth_port_bidir_line_oe,
  input  wire logic              fourth_port_input_line,
  output var  logic              irq
);

  if (ADDR_W < 6) begin : g_check
    $error("fpio_top: ADDR_W must be at least 6");
  end

  fpio_pkg::fpio_state_type s_q;
  fpio_pkg::fpio_state_type s_d;

  // Decode: bit 4 set when the word is mapped
  function automatic logic [4:0] fpio_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] word;
    logic              hit;
    word = a >> `FPIO_WORD_LSB;
    hit  = (word <= ADDR_W'(`FPIO_IDX_LAST));
    return {hit, a[`FPIO_WORD_LSB+`FPIO_IDX_W-1:`FPIO_WORD_LSB]};
  endfunction : fpio_decode

  // Latch for outputs, pin for inputs
  function automatic logic [7:0] fpio_mix(input logic [7:0] dir,
                                          input logic [7:0] lat,
                                          input logic [7:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction : fpio_mix

  logic       aw_take;
  logic       w_take;
  logic       wr_go;
  logic [4:0] wr_sel;
  logic [7:0] wr_byte;
  logic       wr_strb;
  logic [7:0] key_fall;

  assign aw_take  = s_axi_awvalid & s_q.awready;
  assign w_take   = s_axi_wvalid & s_q.wready;
  assign wr_sel   = s_q.aw_got ? s_q.aw_sel : fpio_decode(s_axi_awaddr);
  assign wr_byte  = s_q.w_got ? s_q.w_data : s_axi_wdata[7:0];
  assign wr_strb  = s_q.w_got ? s_q.w_strb : s_axi_wstrb[0];
  assign wr_go    = (s_q.aw_got | aw_take) & (s_q.w_got | w_take) & ~s_q.bvalid & aresetn;
  // Falling edges on first port lines act like the external request pin
  assign key_fall = s_q.cfg[`FPIO_CFG_KEY_BIT] ? (s_q.prev_a & ~port_a_in) : 8'h00;

  always_comb begin
    logic [4:0] rsel;
    logic [7:0] rv;
    rsel = 5'h00;
    rv   = 8'h00;
    s_d  = s_q;

    // Write address and data taken in either order
    if (aw_take) begin
      s_d.aw_got = 1'b1;
      s_d.aw_sel = fpio_decode(s_axi_awaddr);
    end
    if (w_take) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_strb = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = wr_sel[4] ? `FPIO_RESP_OKAY : `FPIO_RESP_SLVERR;
      if (wr_sel[4] && wr_strb) begin
        case (wr_sel[3:0])
          `FPIO_IDX_A_DATA: begin
            s_d.dat_a = wr_byte;
          end
          `FPIO_IDX_B_DATA: begin
            s_d.dat_b = wr_byte[`FPIO_B_MSB:`FPIO_B_LSB];
          end
          `FPIO_IDX_C_DATA: begin
            s_d.dat_c = wr_byte;
          end
          `FPIO_IDX_D_DATA: begin
            s_d.dat_d = wr_byte[`FPIO_D_BIDIR_BIT];
          end
          `FPIO_IDX_A_DIR: begin
            s_d.dir_a = wr_byte;
          end
          `FPIO_IDX_B_DIR: begin
            s_d.dir_b = wr_byte[`FPIO_B_MSB:`FPIO_B_LSB];
          end
          `FPIO_IDX_C_DIR: begin
            s_d.dir_c = wr_byte;
          end
          `FPIO_IDX_D_DIR: begin
            s_d.dir_d = wr_byte[`FPIO_D_BIDIR_BIT];
          end
          `FPIO_IDX_CLEAR: begin
            s_d.stat = s_q.stat & ~wr_byte;
          end
          `FPIO_IDX_ENABLE: begin
            s_d.en = wr_byte;
          end
          `FPIO_IDX_CONFIG: begin
            s_d.cfg = wr_byte[`FPIO_CFG_MSB:0];
          end
          default: begin
            s_d.cfg = s_d.cfg;
          end
        endcase
      end
    end

    // New events win over a clear in the same cycle
    s_d.stat   = s_d.stat | key_fall;
    s_d.prev_a = port_a_in;

    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      rsel = fpio_decode(s_axi_araddr);
      if (rsel[4]) begin
        case (rsel[3:0])
          `FPIO_IDX_A_DATA: begin
            rv = fpio_mix(s_q.dir_a, s_q.dat_a, port_a_in);
          end
          `FPIO_IDX_B_DATA: begin
            rv = fpio_mix({s_q.dir_b, 5'h00}, {s_q.dat_b, 5'h00},
                          {second_port_lines_in, 5'h00});
          end
          `FPIO_IDX_C_DATA: begin
            rv = fpio_mix(s_q.dir_c, s_q.dat_c, port_c_in);
          end
          `FPIO_IDX_D_DATA: begin
            rv[`FPIO_D_BIDIR_BIT] = s_q.dir_d ? s_q.dat_d : fourth_port_bidir_line_in;
            rv[`FPIO_D_INPUT_BIT] = fourth_port_input_line;
          end
          `FPIO_IDX_A_DIR: begin
            rv = s_q.dir_a;
          end
          `FPIO_IDX_B_DIR: begin
            rv[`FPIO_B_MSB:`FPIO_B_LSB] = s_q.dir_b;
          end
          `FPIO_IDX_C_DIR: begin
            rv = s_q.dir_c;
          end
          `FPIO_IDX_D_DIR: begin
            rv[`FPIO_D_BIDIR_BIT] = s_q.dir_d;
          end
          `FPIO_IDX_STATUS: begin
            rv = s_q.stat;
          end
          `FPIO_IDX_ENABLE: begin
            rv = s_q.en;
          end
          `FPIO_IDX_CONFIG: begin
            rv[`FPIO_CFG_MSB:0] = s_q.cfg;
          end
          default: begin
            rv = 8'h00;
          end
        endcase
      end
      s_d.rvalid = 1'b1;
      s_d.rdata  = rv;
      s_d.rresp  = rsel[4] ? `FPIO_RESP_OKAY : `FPIO_RESP_SLVERR;
    end

    if (!aresetn) begin
      s_d.dat_a   = s_q.dat_a;
      s_d.dat_b   = s_q.dat_b;
      s_d.dat_c   = s_q.dat_c;
      s_d.dat_d   = s_q.dat_d;
      s_d.dir_a   = `FPIO_DIR_RESET;
      s_d.dir_b   = `FPIO_DIRB_RESET;
      s_d.dir_c   = `FPIO_DIR_RESET;
      s_d.dir_d   = 1'b0;
      s_d.stat    = `FPIO_STAT_RESET;
      s_d.en      = `FPIO_EN_RESET;
      s_d.cfg     = `FPIO_CFG_RESET;
      s_d.prev_a  = 8'h00;
      s_d.aw_got  = 1'b0;
      s_d.aw_sel  = 5'h00;
      s_d.w_got   = 1'b0;
      s_d.w_data  = 8'h00;
      s_d.w_strb  = 1'b0;
      s_d.bvalid  = 1'b0;
      s_d.bresp   = `FPIO_RESP_OKAY;
      s_d.rvalid  = 1'b0;
      s_d.rresp   = `FPIO_RESP_OKAY;
      s_d.rdata   = 8'h00;
    end

    // Pin drivers; fourth port ignores the timer entirely
    s_d.oe_a    = s_d.dir_a;
    s_d.oe_b    = s_d.cfg[`FPIO_CFG_SPE_BIT] ? 3'h0 : s_d.dir_b;
    s_d.oe_c    = s_d.cfg[`FPIO_CFG_ADC_BIT] ? (s_d.dir_c & ~`FPIO_C_SHARED)
                                             : s_d.dir_c;
    s_d.oe_d    = s_d.dir_d;
    s_d.pull    = s_d.cfg[`FPIO_CFG_PULL_BIT];
    s_d.irq     = |(s_d.stat & s_d.en);
    s_d.awready = ~s_d.aw_got & ~s_d.bvalid & aresetn;
    s_d.wready  = ~s_d.w_got & ~s_d.bvalid & aresetn;
    s_d.arready = ~s_d.rvalid & aresetn;
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign s_axi_awready              = s_q.awready;
  assign s_axi_wready               = s_q.wready;
  assign s_axi_bresp                = s_q.bresp;
  assign s_axi_bvalid               = s_q.bvalid;
  assign s_axi_arready              = s_q.arready;
  assign s_axi_rdata                = {24'h000000, s_q.rdata};
  assign s_axi_rresp                = s_q.rresp;
  assign s_axi_rvalid               = s_q.rvalid;
  assign port_a_out                 = s_q.dat_a;
  assign port_a_oe                  = s_q.oe_a;
  assign port_a_pullup              = s_q.pull;
  assign second_port_lines_out      = s_q.dat_b;
  assign second_port_lines_oe       = s_q.oe_b;
  assign port_c_out                 = s_q.dat_c;
  assign port_c_oe                  = s_q.oe_c;
  assign fourth_port_bidir_line_out = s_q.dat_d;
  assign fourth_port_bidir_line_oe  = s_q.oe_d;
  assign irq                        = s_q.irq;

  // Checks
  a_dir_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (s_q.dir_a == 8'h00) && (s_q.dir_b == 3'h0) && (s_q.dir_c == 8'h00)
      && !s_q.dir_d && (port_a_oe == 8'h00) && (port_c_oe == 8'h00)
      && (second_port_lines_oe == 3'h0) && !fourth_port_bidir_line_oe)
    else $error("direction not cleared by reset");

  a_data_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (port_c_out === $past(port_c_out)) && (port_a_out === $past(port_a_out)))
    else $error("data latch changed across reset");

  a_read_mix: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && fpio_decode(s_axi_araddr) == {1'b1, `FPIO_IDX_A_DATA})
      |=> s_axi_rvalid && (s_axi_rdata[7:0] == (($past(s_q.dir_a) & $past(port_a_out))
          | (~$past(s_q.dir_a) & $past(port_a_in)))))
    else $error("first port read mix wrong");

  a_dir_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && wr_strb && wr_sel == {1'b1, `FPIO_IDX_A_DIR}) |=> (port_a_oe == $past(wr_byte)))
    else $error("first port enable does not follow direction write");

  a_input_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && wr_strb && wr_sel == {1'b1, `FPIO_IDX_C_DATA} && s_q.dir_c == 8'h00)
      |=> (port_c_oe == 8'h00) && (port_c_out == $past(wr_byte)))
    else $error("input pin write disturbed pin or lost latch");

  a_serial_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.cfg[`FPIO_CFG_SPE_BIT] |-> (second_port_lines_oe == 3'h0))
    else $error("second port driven while serial enabled");

  a_conv_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.cfg[`FPIO_CFG_ADC_BIT] |-> ((port_c_oe & `FPIO_C_SHARED) == 8'h00)
      && (port_c_oe == (s_q.dir_c & ~`FPIO_C_SHARED)))
    else $error("third port shared lines driven while converter on");

  a_fourth_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && wr_strb && wr_sel == {1'b1, `FPIO_IDX_D_DIR})
      |=> (fourth_port_bidir_line_oe == $past(wr_byte[`FPIO_D_BIDIR_BIT])))
    else $error("fourth port direction bit misplaced");

  a_fourth_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && fpio_decode(s_axi_araddr) == {1'b1, `FPIO_IDX_D_DATA})
      |=> (s_axi_rdata[7] == $past(fourth_port_input_line))
          && ((s_axi_rdata[7:0] & 8'h5F) == 8'h00))
    else $error("fourth port read wrong");

  a_pull_option: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(s_q.cfg) |=> (port_a_pullup == $past(s_q.cfg[`FPIO_CFG_PULL_BIT], 1)))
    else $error("pull-up does not follow option");

  a_key_event: assert property (@(posedge aclk) disable iff (!aresetn)
    (key_fall != 8'h00) |=> ((s_q.stat & $past(key_fall)) == $past(key_fall)) ##1
      ($past(key_fall, 2) == 8'h00 || irq == |(s_q.stat & s_q.en)))
    else $error("first port edge lost");

  a_bit_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && fpio_decode(s_axi_araddr) == {1'b1, `FPIO_IDX_B_DIR})
      |=> (s_axi_rdata[4:0] == 5'h00) && (s_axi_rdata[7:5] == $past(s_q.dir_b)))
    else $error("unimplemented second port bits not zero");

  a_b_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && wr_strb && wr_sel == {1'b1, `FPIO_IDX_B_DIR} && !s_q.cfg[`FPIO_CFG_SPE_BIT])
      |=> (second_port_lines_oe == $past(wr_byte[`FPIO_B_MSB:`FPIO_B_LSB])))
    else $error("second port enable does not follow direction write");

  a_c_read_mix: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && fpio_decode(s_axi_araddr) == {1'b1, `FPIO_IDX_C_DATA})
      |=> s_axi_rvalid && (s_axi_rdata[7:0] == (($past(s_q.dir_c) & $past(port_c_out))
          | (~$past(s_q.dir_c) & $past(port_c_in)))))
    else $error("third port read mix wrong");

  a_d_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && wr_strb && wr_sel == {1'b1, `FPIO_IDX_D_DATA})
      |=> (fourth_port_bidir_line_out == $past(wr_byte[`FPIO_D_BIDIR_BIT]))
          && (fourth_port_bidir_line_oe == $past(fourth_port_bidir_line_oe)))
    else $error("fourth port latch write wrong");

  a_b_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && fpio_decode(s_axi_araddr) == {1'b1, `FPIO_IDX_B_DATA})
      |=> (s_axi_rdata[4:0] == 5'h00) && (s_axi_rdata[31:8] == 24'h000000))
    else $error("second port data read has stray bits");

  a_clear_stat: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && wr_strb && wr_sel == {1'b1, `FPIO_IDX_CLEAR})
      |=> ((s_q.stat & $past(wr_byte) & ~$past(key_fall)) == 8'h00))
    else $error("status clear lost");

  a_stat_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!(wr_go && wr_sel == {1'b1, `FPIO_IDX_CLEAR}) && (key_fall == 8'h00))
      |=> (s_q.stat == $past(s_q.stat)))
    else $error("status changed without event or clear");

endmodule : fpio_top

`default_nettype wire

// ==== fpio_board_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module fpio_board_model (
  input  wire logic [7:0] ext_a,
  input  wire logic [7:0] ext_b,
  input  wire logic [7:0] ext_c,
  input  wire logic [7:0] ext_d,
  input  wire logic [7:0] a_out,
  input  wire logic [7:0] a_oe,
  input  wire logic [2:0] b_out,
  input  wire logic [2:0] b_oe,
  input  wire logic [7:0] c_out,
  input  wire logic [7:0] c_oe,
  input  wire logic       d_out,
  input  wire logic       d_oe,
  output logic      [7:0] a_in,
  output logic      [2:0] b_in,
  output logic      [7:0] c_in,
  output logic            d_in,
  output logic            d_line
);
  // Driven lines follow the device, released lines follow the board
  assign a_in   = (a_oe & a_out) | (~a_oe & ext_a);
  assign b_in   = (b_oe & b_out) | (~b_oe & ext_b[7:5]);
  assign c_in   = (c_oe & c_out) | (~c_oe & ext_c);
  assign d_in   = d_oe ? d_out : ext_d[5];
  // Input-only line always from the board
  assign d_line = ext_d[7];
endmodule : fpio_board_model

`default_nettype wire

// ==== test_four_port_parallel_io.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fpio_defines.svh"

module test_four_port_parallel_io;
  logic        aclk, aresetn, irq, pull;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dirm;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, d_in, d_out, d_oe, d_line;
  logic [7:0]  a_in, a_out, a_oe, c_in, c_out, c_oe;
  logic [2:0]  b_in, b_out, b_oe;
  logic [7:0]  ext [4];
  int          error_cnt, comparisons, p;
  localparam logic [7:0] DMASK [4] = '{8'hFF, 8'hE0, 8'hFF, 8'hA0};
  localparam logic [7:0] RMASK [4] = '{8'hFF, 8'hE0, 8'hFF, 8'h20};
  localparam logic [7:0] LATCH     = 8'h5A;

  fpio_top #(.ADDR_W(8)) fpio_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_a_in(a_in),
    .port_a_out(a_out), .port_a_oe(a_oe), .port_a_pullup(pull), .second_port_lines_in(b_in),
    .second_port_lines_out(b_out), .second_port_lines_oe(b_oe), .port_c_in(c_in),
    .port_c_out(c_out), .port_c_oe(c_oe), .fourth_port_bidir_line_in(d_in),
    .fourth_port_bidir_line_out(d_out), .fourth_port_bidir_line_oe(d_oe),
    .fourth_port_input_line(d_line), .irq(irq)
  );

  fpio_board_model fpio_board_model_inst (
    .ext_a(ext[0]), .ext_b(ext[1]), .ext_c(ext[2]), .ext_d(ext[3]), .a_out(a_out),
    .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .c_out(c_out), .c_oe(c_oe), .d_out(d_out),
    .d_oe(d_oe), .a_in(a_in), .b_in(b_in), .c_in(c_in), .d_in(d_in), .d_line(d_line)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [7:0] oe_of(input int q);
    case (q)
      0: return a_oe;
      1: return {b_oe, 5'h00};
      2: return c_oe;
      default: return {2'h0, d_oe, 5'h00};
    endcase
  endfunction : oe_of

  function automatic logic [7:0] out_of(input int q);
    case (q)
      0: return a_out;
      1: return {b_out, 5'h00};
      2: return c_out;
      default: return {2'h0, d_out, 5'h00};
    endcase
  endfunction : out_of

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    int         n;
    logic       aw_hit, w_hit, b_hit;
    logic [1:0] resp;
    b_hit = 1'b0;
    resp  = 2'h0;
    @(posedge aclk);
    s_axi_awaddr  <= {2'h0, idx, 2'h0};
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50 && !b_hit; n++) begin
      @(negedge aclk);
      aw_hit = (s_axi_awvalid & s_axi_awready) === 1'b1;
      w_hit  = (s_axi_wvalid & s_axi_wready) === 1'b1;
      b_hit  = s_axi_bvalid === 1'b1;
      resp   = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b_hit) begin
      error_cnt++;
      conclude();
    end
    chk("bresp", (idx > `FPIO_IDX_LAST) ? `FPIO_RESP_SLVERR : `FPIO_RESP_OKAY, resp);
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    int          n;
    logic        ar_hit, r_hit;
    logic [31:0] dat;
    logic [1:0]  resp;
    r_hit = 1'b0;
    dat   = 32'h00000000;
    resp  = 2'h0;
    @(posedge aclk);
    s_axi_araddr  <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50 && !r_hit; n++) begin
      @(negedge aclk);
      ar_hit = (s_axi_arvalid & s_axi_arready) === 1'b1;
      r_hit  = s_axi_rvalid === 1'b1;
      dat    = s_axi_rdata;
      resp   = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!r_hit) begin
      error_cnt++;
      conclude();
    end
    chk("rdata", {24'h000000, exp}, dat);
    chk("rresp", (idx > `FPIO_IDX_LAST) ? `FPIO_RESP_SLVERR : `FPIO_RESP_OKAY, resp);
  endtask : rd

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    ext = '{8'hC3, 8'hA0, 8'h69, 8'h80};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (p = 0; p < 4; p++) begin
      rd(4'(p + 4), 8'h00);
      chk("oe", 8'h00, oe_of(p));
    end
    $display("test reset done");
    for (p = 0; p < 4; p++) begin
      wr(4'(p), LATCH);
      chk("oe", 8'h00, oe_of(p));
      rd(4'(p), ext[p] & DMASK[p]);
      wr(4'(p + 4), 8'h3C);
      dirm = 8'h3C & RMASK[p];
      rd(4'(p + 4), dirm);
      rd(4'(p), ((dirm & LATCH) | (~dirm & ext[p])) & DMASK[p]);
      chk("oe", dirm, oe_of(p));
      chk("out", LATCH & dirm, out_of(p) & dirm);
    end
    $display("test ports done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (p = 0; p < 4; p++) begin
      chk("oe", 8'h00, oe_of(p));
      chk("latch", LATCH & RMASK[p], out_of(p));
    end
    $display("test second reset done");
    wr(`FPIO_IDX_B_DIR, 8'hE0);
    wr(`FPIO_IDX_C_DIR, 8'hFF);
    wr(`FPIO_IDX_CONFIG, 8'h03);
    chk("b oe", 3'h0, b_oe);
    chk("c oe", 8'h07, c_oe);
    rd(`FPIO_IDX_B_DIR, 8'hE0);
    wr(`FPIO_IDX_CONFIG, 8'h00);
    chk("b oe", 3'h7, b_oe);
    chk("c oe", 8'hFF, c_oe);
    $display("test shared done");
    ext[0] <= 8'hFF;
    wr(`FPIO_IDX_CONFIG, 8'h0C);
    chk("pullup", 1'b1, pull);
    wr(`FPIO_IDX_CLEAR, 8'hFF);
    rd(`FPIO_IDX_STATUS, 8'h00);
    ext[0] <= 8'hFE;
    repeat (3) @(posedge aclk);
    chk("irq", 1'b0, irq);
    rd(`FPIO_IDX_STATUS, 8'h01);
    wr(`FPIO_IDX_ENABLE, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq", 1'b1, irq);
    wr(`FPIO_IDX_ENABLE, 8'h00);
    repeat (2) @(posedge aclk);
    chk("irq", 1'b0, irq);
    wr(`FPIO_IDX_CLEAR, 8'h01);
    rd(`FPIO_IDX_STATUS, 8'h00);
    rd(`FPIO_IDX_CLEAR, 8'h00);
    $display("test interrupt done");
    wr(4'hC, 8'hFF);
    rd(4'hC, 8'h00);
    s_axi_wstrb <= 4'hE;
    wr(`FPIO_IDX_ENABLE, 8'hFF);
    rd(`FPIO_IDX_ENABLE, 8'h00);
    s_axi_wstrb <= 4'hF;
    $display("test unmapped done");
    conclude();
  end
endmodule : test_four_port_parallel_io

`default_nettype wire
